/* File: mcarr_buf.sv */
// two-entry buffer with registered ready toward the filling side
// assumes in and out share mclk_i
`timescale 1ns/1ps
module mcarr_buf
    import mcarr_pkg::*;
#(
    parameter int DW    = 8,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic   mclk_i,
    input  wire logic   rstn_i,
    mcarr_stream_if.snk in_s,
    mcarr_stream_if.src out_s
);
    // ========================================================================
    // checks
    if (DEPTH != 2) begin : g_chk
        $error("buffer depth must be two");
    end

    logic [DW-1:0] mem_q [DEPTH];
    logic          wr_ptr_q;
    logic          rd_ptr_q;
    logic [1:0]    cnt_q;
    logic [1:0]    cnt_d;
    logic          ready_q;
    logic          push;
    logic          pop;

    assign push        = in_s.valid && ready_q;
    assign pop         = out_s.valid && out_s.ready;
    assign in_s.ready  = ready_q;
    assign out_s.valid = cnt_q != 2'h0;
    assign out_s.data  = mem_q[rd_ptr_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    // ========================================================================
    // occupancy and ready
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q   <= 2'h0;
            ready_q <= 1'b1;
        end else begin
            cnt_q   <= cnt_d;
            ready_q <= cnt_d != 2'h2;
        end
    end

    // ========================================================================
    // pointers
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
        end
    end

    // ========================================================================
    // storage
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_s.data;
        end
    end
endmodule

/* File: mcarr_ctrl_model.sv */
// display controller model: link word writes and clocking requests
// assumes tasks are entered and left at a falling clock edge
`timescale 1ns/1ps
module mcarr_ctrl_model (
    input  wire logic        mclk_i,
    input  wire logic        ready_i,
    input  wire logic        busy_i,
    output logic             valid_o,
    output logic [2:0]       row_o,
    output logic [0:0]       col_o,
    output logic [15:0]      rise_o,
    output logic [15:0]      fall_o,
    output logic             req_o,
    output logic [1:0]       mask_o
);
    initial begin
        valid_o = 1'b0;
        {row_o, col_o, rise_o, fall_o} = '0;
        req_o = 1'b0;
        mask_o = 2'h0;
    end
    // ========================================================================
    // one link word, held until taken
    task automatic send(input logic [2:0] r, input logic [0:0] c, input logic [15:0] lo, input logic [15:0] hi);
        valid_o <= 1'b1;
        {row_o, col_o, rise_o, fall_o} <= {r, c, lo, hi};
        do @(posedge mclk_i); while (ready_i !== 1'b1);
        @(negedge mclk_i);
    endtask
    // released lines stop showing the last word
    task automatic idle();
        valid_o <= 1'b0;
        {row_o, col_o, rise_o, fall_o} <= ~{row_o, col_o, rise_o, fall_o};
    endtask
    // clocking request only once the block is idle (busy_i low)
    task automatic pulse(input logic [1:0] m);
        while (busy_i !== 1'b0) @(negedge mclk_i);
        req_o <= 1'b1;
        mask_o <= m;
        @(negedge mclk_i);
        req_o <= 1'b0;
        mask_o <= ~m;
    endtask
endmodule

/* File: mcarr_pkg.sv */
// constants shared by the micromirror cell array update block
// assumes a single 125 MHz clock and a link already split into rise and fall words
package mcarr_pkg;
    // ========================================================================
    // array geometry
    localparam int ACTIVE_COLS   = 1920;
    localparam int ACTIVE_ROWS   = 1080;
    localparam int BORDER_W      = 14;
    localparam int NUM_GROUPS    = 15;
    localparam int LINK_WORD_W   = 16;
    // ========================================================================
    // timing
    localparam int CLK_MHZ       = 125;
    localparam int PULSE_NS      = 16;
    localparam int PULSE_CYC     = (PULSE_NS * CLK_MHZ + 999) / 1000;
    // ========================================================================
    // buffer and reset values
    localparam int BUF_DEPTH     = 2;
    localparam logic CELL_RST    = 1'b0;
    localparam logic MIRROR_RST  = 1'b0;

    typedef enum logic [0:0] {
        MCARR_IDLE  = 1'b0,
        MCARR_PULSE = 1'b1
    } mcarr_state_t;
endpackage

/* File: mcarr_props.sv */
// assertions on the ports of the mirror cell array top
// assumes one clock; rows and groups come from the bind, columns stay at the bench's 64
`timescale 1ns/1ps
module mcarr_props #(
    parameter int ROWS   = 8,
    parameter int COLS   = 64,
    parameter int GROUPS = 2
) (
    input wire logic                       mclk_i,
    input wire logic                       rstn_i,
    input wire logic                       reset_req_i,
    input wire logic [GROUPS-1:0]          reset_mask_i,
    input wire logic [GROUPS-1:0]          mirror_group_reset_o,
    input wire logic                       busy_o,
    input wire logic [ROWS-1:0][COLS-1:0]  cell_true_o,
    input wire logic [ROWS-1:0][COLS-1:0]  cell_inverse_output_o,
    input wire logic [ROWS-1:0][COLS-1:0]  mirror_on_o,
    input wire logic                       inactive_border_band_bias_o,
    input wire logic                       inactive_border_band_on_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // ========================================================================
    // cell, pulse and tilt relations
    inv_pair_a: assert property (cell_inverse_output_o == ~cell_true_o)
        else $error("inverse outputs differ from cells");
    border_dark_a: assert property (!inactive_border_band_on_o)
        else $error("border band turned on");
    bias_set_a: assert property ($rose(busy_o) |-> ##[0:2] inactive_border_band_bias_o)
        else $error("border bias missing after pulse");
    bias_keep_a: assert property (inactive_border_band_bias_o |=> inactive_border_band_bias_o)
        else $error("border bias dropped");
    pulse_start_a: assert property (reset_req_i && !busy_o |=> busy_o && mirror_group_reset_o == $past(reset_mask_i))
        else $error("pulse not started with request mask");
    pulse_len_a: assert property ($rose(busy_o) |-> busy_o[*2] ##1 !busy_o)
        else $error("pulse length wrong");
    group_idle_a: assert property (!busy_o |-> mirror_group_reset_o == '0)
        else $error("group pulse outside busy");
    tilt_hold_a: assert property (!(reset_req_i && !busy_o) |=> $stable(mirror_on_o))
        else $error("tilt changed without pulse");
    for (genvar r = 0; r < ROWS; r++) begin : g_row
        row_load_a: assert property (reset_req_i && !busy_o |=> mirror_on_o[r] ==
            ($past(reset_mask_i[r/(ROWS/GROUPS)]) ? $past(cell_true_o[r]) : $past(mirror_on_o[r])))
            else $error("row tilt not loaded as masked");
    end
endmodule

bind mcarr_top mcarr_props #(.ROWS(ROWS), .GROUPS(GROUPS)) u_props (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .reset_req_i(reset_req_i), .reset_mask_i(reset_mask_i),
    .mirror_group_reset_o(mirror_group_reset_o), .busy_o(busy_o), .cell_true_o(cell_true_o),
    .cell_inverse_output_o(cell_inverse_output_o), .mirror_on_o(mirror_on_o),
    .inactive_border_band_bias_o(inactive_border_band_bias_o),
    .inactive_border_band_on_o(inactive_border_band_on_o));

/* File: mcarr_stream_if.sv */
// valid/ready word stream between the link side and the array writer
// assumes both ends on the same clock
`timescale 1ns/1ps
interface mcarr_stream_if #(
    parameter int DW = 8
);
    logic          valid;
    logic          ready;
    logic [DW-1:0] data;

    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface

/* File: mcarr_top.sv */
// micromirror cell array: link writes, cell storage, grouped mirror clocking
// assumes link words are already deserialised and synchronous to mclk_i
`timescale 1ns/1ps
module mcarr_top
    import mcarr_pkg::*;
#(
    parameter int COLS   = ACTIVE_COLS,
    parameter int ROWS   = ACTIVE_ROWS,
    parameter int WORD_W = LINK_WORD_W,
    parameter int GROUPS = NUM_GROUPS,
    parameter int BORDER = BORDER_W,
    parameter int RW     = $clog2(ROWS),
    parameter int CWN    = COLS / (2 * WORD_W),
    parameter int CW     = (CWN > 1) ? $clog2(CWN) : 1
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rstn_i,
    input  wire logic                   link_valid_i,
    input  wire logic [RW-1:0]          link_row_i,
    input  wire logic [CW-1:0]          link_col_i,
    input  wire logic [WORD_W-1:0]      link_rise_data_i,
    input  wire logic [WORD_W-1:0]      link_fall_data_i,
    output logic                        link_ready_o,
    input  wire logic                   reset_req_i,
    input  wire logic [GROUPS-1:0]      reset_mask_i,
    output logic [GROUPS-1:0]           mirror_group_reset_o,
    output logic                        busy_o,
    output logic [ROWS-1:0][COLS-1:0]   cell_true_o,
    output logic [ROWS-1:0][COLS-1:0]   cell_inverse_output_o,
    output logic [ROWS-1:0][COLS-1:0]   mirror_on_o,
    output logic                        inactive_border_band_bias_o,
    output logic                        inactive_border_band_on_o
);
    localparam int PW    = RW + CW + 2 * WORD_W;
    localparam int RPG   = ROWS / GROUPS;
    localparam int PCW   = $clog2(PULSE_CYC + 1);

    // ========================================================================
    // checks
    if ((COLS % (2 * WORD_W)) != 0 || (ROWS % GROUPS) != 0 || BORDER < 1 || PULSE_CYC < 1) begin : g_chk
        $error("array geometry cannot be served");
    end

    // group that owns a row
    function automatic int grp_of(input int row);
        return row / RPG;
    endfunction

    // ========================================================================
    // link input through two-entry buffer
    mcarr_stream_if #(.DW(PW)) link_s ();
    mcarr_stream_if #(.DW(PW)) wr_s ();

    assign link_s.valid = link_valid_i;
    assign link_s.data  = {link_row_i, link_col_i, link_fall_data_i, link_rise_data_i};

    mcarr_buf #(
        .DW    (PW),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .in_s   (link_s),
        .out_s  (wr_s)
    );

    assign link_ready_o = link_s.ready;

    // ========================================================================
    // pulse sequencer
    mcarr_state_t    state_q;
    logic [PCW-1:0]  pcnt_q;
    logic            start;
    logic            wr_go;
    logic [RW-1:0]   wr_row;
    logic [CW-1:0]   wr_col;
    logic [2*WORD_W-1:0] wr_data;

    // a pending reset request holds off writes so the pulse sees loaded cells
    assign start       = (state_q == MCARR_IDLE) && reset_req_i;
    assign wr_s.ready  = (state_q == MCARR_IDLE) && !reset_req_i;
    assign wr_go       = wr_s.valid && wr_s.ready;
    assign wr_row      = wr_s.data[PW-1 -: RW];
    assign wr_col      = wr_s.data[2*WORD_W +: CW];
    assign wr_data     = wr_s.data[2*WORD_W-1:0];

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= MCARR_IDLE;
            pcnt_q  <= '0;
        end else begin
            unique case (state_q)
                MCARR_IDLE: begin
                    if (start) begin
                        state_q <= MCARR_PULSE;
                        pcnt_q  <= PCW'(PULSE_CYC - 1);
                    end
                end
                MCARR_PULSE: begin
                    if (pcnt_q == '0) begin
                        state_q <= MCARR_IDLE;
                    end else begin
                        pcnt_q <= pcnt_q - PCW'(1);
                    end
                end
            endcase
        end
    end

    // ========================================================================
    // group reset pins and busy
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mirror_group_reset_o <= '0;
            busy_o               <= 1'b0;
        end else begin
            if (start) begin
                mirror_group_reset_o <= reset_mask_i;
                busy_o               <= 1'b1;
            end else if (state_q == MCARR_PULSE && pcnt_q == '0) begin
                mirror_group_reset_o <= '0;
                busy_o               <= 1'b0;
            end
        end
    end

    // ========================================================================
    // storage cells, true and inverse
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cell_true_o           <= {ROWS{{COLS{CELL_RST}}}};
            cell_inverse_output_o <= {ROWS{{COLS{~CELL_RST}}}};
        end else if (wr_go) begin
            cell_true_o[wr_row][wr_col*2*WORD_W +: 2*WORD_W]           <= wr_data;
            cell_inverse_output_o[wr_row][wr_col*2*WORD_W +: 2*WORD_W] <= ~wr_data;
        end
    end

    // ========================================================================
    // mirror tilt: 1 = positive = on, 0 = negative = off
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mirror_on_o <= {ROWS{{COLS{MIRROR_RST}}}};
        end else if (start) begin
            for (int r = 0; r < ROWS; r++) begin
                if (reset_mask_i[grp_of(r)]) begin
                    mirror_on_o[r] <= cell_true_o[r];
                end
            end
        end
    end

    // ========================================================================
    // border band: biased toward off once clocking starts, never on
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            inactive_border_band_bias_o <= 1'b0;
            inactive_border_band_on_o   <= 1'b0;
        end else begin
            if (start) begin
                inactive_border_band_bias_o <= 1'b1;
            end
            inactive_border_band_on_o <= 1'b0;
        end
    end

endmodule

/* File: micromirror_cell_array_update_tb_top.sv */
// self-checking bench for the mirror cell array top, small geometry
// assumes the controller model drives every link and clocking input
`timescale 1ns/1ps
module micromirror_cell_array_update_tb_top;
    logic                mclk_i = 1'b0;
    logic                rstn_i = 1'b0;
    logic                valid, req, ready, busy, bias, bon, full_seen;
    logic [2:0]          row;
    logic [0:0]          col;
    logic [15:0]         lo, hi;
    logic [1:0]          mask, grp;
    logic [7:0][63:0]    cell_t, cell_n, mir;
    int                  bad_count = 0;
    int                  check_count = 0;
    int                  cyc = 0;
    always #4 mclk_i = ~mclk_i;
    mcarr_ctrl_model u_ctrl (.mclk_i(mclk_i), .ready_i(ready), .busy_i(busy), .valid_o(valid), .row_o(row),
        .col_o(col), .rise_o(lo), .fall_o(hi), .req_o(req), .mask_o(mask));
    mcarr_top #(.COLS(64), .ROWS(8), .GROUPS(2)) DUT (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .link_valid_i(valid), .link_row_i(row), .link_col_i(col), .link_rise_data_i(lo), .link_fall_data_i(hi),
        .link_ready_o(ready), .reset_req_i(req), .reset_mask_i(mask), .mirror_group_reset_o(grp), .busy_o(busy),
        .cell_true_o(cell_t), .cell_inverse_output_o(cell_n), .mirror_on_o(mir),
        .inactive_border_band_bias_o(bias), .inactive_border_band_on_o(bon));
    // ========================================================================
    // checking and closing
    task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            finish_test();
        end
    end
    always @(negedge mclk_i) if (rstn_i && ready === 1'b0) full_seen = 1'b1;
    // ========================================================================
    // scenarios
    task automatic t_reset();
        chk("ready", {63'h0, ready}, 64'h1);
        chk("cells", cell_t[7], 64'h0);
        chk("inverse", cell_n[0], 64'hFFFFFFFFFFFFFFFF);
        chk("mirrors", mir[0], 64'h0);
        chk("pulses", {62'h0, grp}, 64'h0);
    endtask
    task automatic t_write();
        u_ctrl.send(3'h1, 1'h0, 16'hA5C3, 16'h0F0F);
        u_ctrl.send(3'h1, 1'h1, 16'h1234, 16'h8001);
        u_ctrl.send(3'h5, 1'h1, 16'hFFFF, 16'h0001);
        u_ctrl.idle();
        repeat (3) @(negedge mclk_i);
        chk("row1", cell_t[1], 64'h80011234_0F0FA5C3);
        chk("row1 inv", cell_n[1], ~64'h80011234_0F0FA5C3);
        chk("row1 tilt", mir[1], 64'h0);
    endtask
    task automatic t_groups();
        u_ctrl.pulse(2'h1);
        chk("grp", {62'h0, grp}, 64'h1);
        repeat (2) @(negedge mclk_i);
        chk("busy", {63'h0, busy}, 64'h0);
        chk("row1 on", mir[1], 64'h80011234_0F0FA5C3);
        chk("row5 kept", mir[5], 64'h0);
        chk("border", {62'h0, bias, bon}, 64'h2);
        u_ctrl.pulse(2'h2);
        repeat (2) @(negedge mclk_i);
        chk("row5 on", mir[5], 64'h0001FFFF_00000000);
        chk("row1 held", mir[1], 64'h80011234_0F0FA5C3);
    endtask
    task automatic t_stall();
        full_seen = 1'b0;
        u_ctrl.pulse(2'h3);
        u_ctrl.send(3'h2, 1'h0, 16'h3C3C, 16'h00F0);
        u_ctrl.send(3'h2, 1'h1, 16'h7E00, 16'hC001);
        u_ctrl.send(3'h6, 1'h0, 16'hAAAA, 16'h5555);
        u_ctrl.idle();
        repeat (4) @(negedge mclk_i);
        chk("full", {63'h0, full_seen}, 64'h1);
        chk("row2", cell_t[2], 64'hC0017E00_00F03C3C);
        chk("row6", cell_t[6], 64'h00000000_5555AAAA);
        chk("row2 tilt", mir[2], 64'h0);
        u_ctrl.pulse(2'h3);
        repeat (2) @(negedge mclk_i);
        chk("row2 on", mir[2], 64'hC0017E00_00F03C3C);
    endtask
    task automatic t_rereset();
        rstn_i <= 1'b0;
        @(negedge mclk_i);
        chk("row2 clr", cell_t[2], 64'h0);
        chk("tilt clr", mir[5], 64'h0);
        rstn_i <= 1'b1;
        @(negedge mclk_i);
    endtask
    initial begin
        repeat (20) @(posedge mclk_i);
        @(negedge mclk_i);
        rstn_i <= 1'b1;
        @(negedge mclk_i);
        t_reset();
        t_write();
        t_groups();
        t_stall();
        t_rereset();
        t_reset();
        finish_test();
    end
endmodule
